//--- common/udc_pkg.sv
// constants for the 4-bit dual-clock up/down counter
package udc_pkg;
	localparam int          UDC_WIDTH    = 4;
	localparam logic [3:0]  UDC_RST_VAL  = 4'h0;
	localparam logic [3:0]  UDC_MAX_VAL  = 4'hF;
	localparam logic [3:0]  UDC_MIN_VAL  = 4'h0;
	typedef logic [UDC_WIDTH-1:0] udc_count_t;
	typedef enum logic [1:0] {
		UDC_HOLD  = 2'b00,
		UDC_UP    = 2'b01,
		UDC_DOWN  = 2'b10,
		UDC_PRESET = 2'b11
	} udc_op_e;
endpackage

//--- rtl/udc_counter.sv
// 4-bit dual-clock up/down counter with preset, clear, carry and borrow
`timescale 1ns/100ps
// What this block does
// [R1] count changes only on a count-input rising edge, a preset or a clear
// [R2] up edge increments, down edge decrements
// [R3] other side holds idle count input high
// [R4] load low makes outputs follow data
// [R5] clear high forces zero, beats everything
// [R6] borrow pulse as wide as count-down low
// [R7] carry pulse as wide as count-up low
// [R8] count wraps modulo sixteen
// [R9] system chains borrow/carry to next stage
// [R10] carry, borrow active low at fifteen, zero
// [R11] inputs sampled, edges detected on clock
module udc_counter (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              count_up,
	input  wire logic              count_down,
	input  wire logic              load_n,
	input  wire logic              clear,
	input  wire udc_pkg::udc_count_t data_in,
	output logic [3:0]             count_out,
	output logic                   carry_n,
	output logic                   borrow_n
);
	import udc_pkg::*;

	// ********************************
	// input sampling
	// ********************************
	logic       up_q;
	logic       down_q;
	logic       load_n_q;
	logic       clear_q;
	udc_count_t data_q;
	logic       up_prev;
	logic       down_prev;

	// reset to the idle-high pin level so no false edge follows reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			up_q      <= 1'b1;
			down_q    <= 1'b1;
			load_n_q  <= 1'b1;
			clear_q   <= 1'b0;
			data_q    <= UDC_RST_VAL;
			up_prev   <= 1'b1;
			down_prev <= 1'b1;
		end else begin
			up_q      <= count_up; // [R11]
			down_q    <= count_down;
			load_n_q  <= load_n;
			clear_q   <= clear;
			data_q    <= data_in;
			up_prev   <= up_q;
			down_prev <= down_q;
		end
	end

	// ********************************
	// counter core
	// ********************************
	udc_op_e    op;
	udc_count_t count;
	udc_count_t next_count;
	logic       up_rise;
	logic       down_rise;

	function automatic udc_count_t udc_step(input udc_count_t v, input logic up);
		udc_step = up ? udc_count_t'(v + 4'h1) : udc_count_t'(v - 4'h1); // [R8]
	endfunction

	always_comb begin
		up_rise   = up_q && !up_prev;   // [R11]
		down_rise = down_q && !down_prev;
		// both rising together breaks the host's contract; treat as hold
		if (!load_n_q) begin
			op = UDC_PRESET;
		end else if (up_rise && !down_rise && down_q) begin
			op = UDC_UP; // [R2]
		end else if (down_rise && !up_rise && up_q) begin
			op = UDC_DOWN; // [R2]
		end else begin
			op = UDC_HOLD;
		end
		next_count = count;
		case (op)
			UDC_PRESET: next_count = data_q;                 // [R4]
			UDC_UP:     next_count = udc_step(count, 1'b1);  // [R1] [R8]
			UDC_DOWN:   next_count = udc_step(count, 1'b0);  // [R1] [R8]
			default:    next_count = count;
		endcase
		if (clear_q) begin
			next_count = UDC_RST_VAL; // [R5]
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= UDC_RST_VAL;
		end else begin
			count <= next_count;
		end
	end

	// ********************************
	// outputs, all registered
	// ********************************
	logic next_carry_n;
	logic next_borrow_n;

	always_comb begin
		// decoded from next state so carry tracks the count pulse exactly
		next_carry_n  = !(next_count == UDC_MAX_VAL && !up_q);   // [R7] [R10]
		next_borrow_n = !(next_count == UDC_MIN_VAL && !down_q); // [R6] [R10]
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_out <= UDC_RST_VAL;
			carry_n   <= 1'b1;
			borrow_n  <= 1'b1;
		end else begin
			count_out <= next_count; // [R1]
			carry_n   <= next_carry_n;
			borrow_n  <= next_borrow_n;
		end
	end

	// ********************************
	// checks
	// ********************************
	sequence s_up_edge;
		up_q && !up_prev && down_q && load_n_q && !clear_q;
	endsequence

	// a clean down edge: up path idle high, no preset, no clear
	sequence s_down_edge;
		down_q && !down_prev && up_q && load_n_q && !clear_q;
	endsequence

	// count-up pin just fell at fifteen, nothing else pending on the pins
	sequence s_up_fall_at_max;
		count == UDC_MAX_VAL && up_q && down_q && load_n_q && !clear_q
		&& load_n && !clear && $fell(count_up);
	endsequence

	sequence s_down_fall_at_min;
		count == UDC_MIN_VAL && down_q && up_q && load_n_q && !clear_q
		&& load_n && !clear && $fell(count_down);
	endsequence

	a_up_increment: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
		s_up_edge and !down_rise |=> count_out == udc_count_t'($past(count) + 4'h1))
		else $error("count did not increment on up edge");
	a_down_decrement: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
		down_rise && up_q && !up_rise && load_n_q && !clear_q
		|=> count_out == udc_count_t'($past(count) - 4'h1))
		else $error("count did not decrement on down edge");
	a_clear_wins: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
		clear_q |=> count_out == UDC_RST_VAL)
		else $error("clear did not zero count");
	a_load_follows: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
		!load_n_q && !clear_q |=> count_out == $past(data_q))
		else $error("preset did not follow data");
	a_no_edge_hold: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
		!up_rise && !down_rise && load_n_q && !clear_q |=> $stable(count_out))
		else $error("count changed without edge");
	a_carry_level: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
		##1 (carry_n == !(count_out == UDC_MAX_VAL && !$past(up_q))))
		else $error("carry wrong");
	a_borrow_level: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
		##1 (borrow_n == !(count_out == UDC_MIN_VAL && !$past(down_q))))
		else $error("borrow wrong");
	// sixteen states only: one step up from fifteen is zero
	a_wrap_up: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
		s_up_edge and !down_rise and count == UDC_MAX_VAL |=> count_out == UDC_MIN_VAL)
		else $error("no wrap to zero");
	a_carry_pulse: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
		s_up_fall_at_max |=> ##1 !carry_n)
		else $error("carry pulse missing");

	// ********************************
	// checks: refused edges and pulse ends
	// ********************************
	// host breaking the idle-high contract must not move the count
	a_both_edges_hold: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
		up_rise && down_rise && load_n_q && !clear_q |=> $stable(count_out))
		else $error("count moved on simultaneous edges");

	// an edge while the other input is low is refused
	a_up_blocked: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
		up_rise && !down_q && load_n_q && !clear_q |=> $stable(count_out))
		else $error("count moved on up edge with down low");

	a_down_blocked: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
		down_rise && !up_q && load_n_q && !clear_q |=> $stable(count_out))
		else $error("count moved on down edge with up low");

	a_wrap_down: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
		s_down_edge and !up_rise and count == UDC_MIN_VAL |=> count_out == UDC_MAX_VAL)
		else $error("no wrap to fifteen");

	// borrow follows the count-down pin low, two clocks behind
	a_borrow_pulse: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
		s_down_fall_at_min |=> ##1 !borrow_n)
		else $error("borrow pulse missing");

	// carry and borrow end with the pulse that caused them, so a cascade sees one edge
	a_carry_release: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
		!carry_n && up_rise |=> carry_n)
		else $error("carry held past the count pulse");

	a_borrow_release: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
		!borrow_n && down_rise |=> borrow_n)
		else $error("borrow held past the count pulse");

	// clear parks the count at zero, which never leaves a carry standing
	a_clear_carry: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
		clear_q |=> carry_n)
		else $error("carry low after clear");
endmodule

//--- sim/udc_ctrl_model.sv
// controlling logic that pulses the count inputs, plus a cascaded upper stage
`timescale 1ns/100ps
module udc_ctrl_model (
	input  wire logic  clock,
	input  wire logic  rst_n,
	input  wire logic  up_req,
	input  wire logic  dn_req,
	input  wire logic  carry_n,
	input  wire logic  borrow_n,
	output logic       count_up,
	output logic       count_down,
	output logic [3:0] upper_count
);
	// idle high; each request drives its own input low directly, so both inputs can be low at once
	assign count_up   = !up_req;
	assign count_down = !dn_req;
	// upper stage counts on the lower stage's carry and borrow, no extra gating
	udc_counter u_dut (
		.clock      (clock),
		.rst_n      (rst_n),
		.count_up   (carry_n),
		.count_down (borrow_n),
		.load_n     (1'b1),
		.clear      (1'b0),
		.data_in    (4'h0),
		.count_out  (upper_count),
		.carry_n    (),
		.borrow_n   ()
	);
endmodule

//--- sim/tb_top.sv
// self-checking bench for the up/down counter
`timescale 1ns/100ps
module tb_top;
	import udc_pkg::*;
	logic clock, rst_n, up_req, dn_req, count_up, count_down, load_n, clear, carry_n, borrow_n;
	udc_count_t data_in;
	logic [3:0] count_out;
	logic [3:0] upper_count;
	int bad_count, checked;
	udc_ctrl_model u_ctrl (.clock(clock), .rst_n(rst_n), .up_req(up_req), .dn_req(dn_req), .carry_n(carry_n),
		.borrow_n(borrow_n), .count_up(count_up), .count_down(count_down), .upper_count(upper_count));
	udc_counter u_dut (.clock(clock), .rst_n(rst_n), .count_up(count_up), .count_down(count_down),
		.load_n(load_n), .clear(clear), .data_in(data_in), .count_out(count_out),
		.carry_n(carry_n), .borrow_n(borrow_n));
	initial begin
		clock = 1'b0;
		forever #5 clock = !clock;
	end
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// input held low two cycles, then high three; outputs land two edges after release
	task automatic pulse(input logic up);
		if (up) begin
			up_req = 1'b1;
		end else begin
			dn_req = 1'b1;
		end
		wt(2);
		up_req = 1'b0;
		dn_req = 1'b0;
		wt(3);
	endtask
	task automatic preset(input logic [3:0] v);
		load_n = 1'b0;
		data_in = v;
		wt(3);
		load_n = 1'b1;
		wt(3);
	endtask
	task automatic t_load();
		preset(4'h3);
		chk("count", 4'h3, count_out);
		load_n = 1'b0;
		data_in = 4'hA;
		wt(3);
		pulse(1'b1);
		chk("count", 4'hA, count_out);
		load_n = 1'b1;
		$display("test load done");
	endtask
	task automatic t_up();
		preset(4'hE);
		pulse(1'b1);
		chk("count", 4'hF, count_out);
		chk("carry_n", 4'h1, {3'h0, carry_n});
		up_req = 1'b1;
		wt(3);
		chk("carry_n", 4'h0, {3'h0, carry_n});
		up_req = 1'b0;
		wt(1);
		chk("carry_n", 4'h0, {3'h0, carry_n});
		wt(2);
		chk("count", 4'h0, count_out);
		chk("carry_n", 4'h1, {3'h0, carry_n});
		$display("test up done");
	endtask
	task automatic t_down();
		preset(4'h1);
		chk("upper_count", 4'h1, upper_count);
		pulse(1'b0);
		chk("count", 4'h0, count_out);
		chk("borrow_n", 4'h1, {3'h0, borrow_n});
		dn_req = 1'b1;
		wt(3);
		chk("borrow_n", 4'h0, {3'h0, borrow_n});
		dn_req = 1'b0;
		wt(1);
		chk("borrow_n", 4'h0, {3'h0, borrow_n});
		wt(2);
		chk("count", 4'hF, count_out);
		chk("borrow_n", 4'h1, {3'h0, borrow_n});
		wt(2);
		chk("upper_count", 4'h0, upper_count);
		$display("test down done");
	endtask
	task automatic t_clear();
		clear = 1'b1;
		load_n = 1'b0;
		data_in = 4'h9;
		wt(3);
		pulse(1'b1);
		chk("count", 4'h0, count_out);
		clear = 1'b0;
		wt(3);
		chk("count", 4'h9, count_out);
		load_n = 1'b1;
		up_req = 1'b1;
		dn_req = 1'b1;
		wt(2);
		pulse(1'b0);
		chk("count", 4'h9, count_out);
		dn_req = 1'b1;
		wt(1);
		up_req = 1'b1;
		wt(2);
		up_req = 1'b0;
		wt(3);
		chk("count", 4'h9, count_out);
		dn_req = 1'b0;
		wt(3);
		chk("count", 4'h8, count_out);
		up_req = 1'b1;
		wt(1);
		dn_req = 1'b1;
		wt(2);
		dn_req = 1'b0;
		wt(3);
		chk("count", 4'h8, count_out);
		up_req = 1'b0;
		wt(3);
		chk("count", 4'h9, count_out);
		$display("test clear done");
	endtask
	initial begin
		{up_req, dn_req, clear, rst_n} = 4'h0;
		load_n = 1'b1;
		data_in = 4'h0;
		wt(5);
		rst_n = 1'b1;
		wt(1);
		t_load();
		t_up();
		t_down();
		t_clear();
		complete_run();
	end
	initial begin
		#20000;
		bad_count++;
		complete_run();
	end
endmodule
